// file: inc/mmd_pkg.sv
// shared constants and carrier types for the memory map decoder
package mmd_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int FLASH_ACCESS_NS = 40;
	localparam int FLASH_ACCESS_CYC_RAW = (FLASH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLASH_ACCESS_CYC = (FLASH_ACCESS_CYC_RAW < 1) ? 1 : FLASH_ACCESS_CYC_RAW;
	localparam logic [1:0] FLASH_WAIT = 2'(FLASH_ACCESS_CYC);
	localparam logic [1:0] PF_MISS_WAIT = 2'h2;
	localparam logic [1:0] PF_HIT_WAIT = 2'h0;
	// code space
	localparam int CODE_BYTES = 16384;
	localparam logic [15:0] CODE_LAST = 16'h3fff;
	// internal data space
	localparam int IRAM_BYTES = 256;
	localparam logic [7:0] DIRECT_LAST = 8'h7f;
	localparam logic [7:0] BIT_AREA_BASE = 8'h20;
	localparam logic [7:0] SP_RESET = 8'h07;
	// external data space
	localparam int ONCHIP_EXTERNAL_RAM_BYTES = 768;
	localparam int ONCHIP_EXTERNAL_RAM_AW = 10;
	// special register offsets and fields
	localparam logic [7:0] PREFETCH_CONTROL_ADDR = 8'hb5;
	localparam logic [7:0] ONCHIP_EXTERNAL_RAM_PAGE_REGISTER_ADDR = 8'haa;
	localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hd0;
	localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
	localparam logic [7:0] PREFETCH_CONTROL_RESET = 8'h20;
	localparam int PREFETCH_ON_BIT = 5;
	localparam int BANK_SELECT_LOW_BIT = 3;
	localparam int BANK_SELECT_HIGH_BIT = 4;
	localparam logic [7:0] PSW_RESET = 8'h00;
	localparam logic [1:0] PAGE_RESET = 2'h0;

	typedef enum logic [3:0] {
		OP_FETCH = 4'h0,
		OP_CODE_RD = 4'h1,
		OP_DIR_RD = 4'h2,
		OP_DIR_WR = 4'h3,
		OP_IND_RD = 4'h4,
		OP_IND_WR = 4'h5,
		OP_BIT_RD = 4'h6,
		OP_BIT_WR = 4'h7,
		OP_PUSH = 4'h8,
		OP_POP = 4'h9,
		OP_X8_RD = 4'ha,
		OP_X8_WR = 4'hb,
		OP_X16_RD = 4'hc,
		OP_X16_WR = 4'hd
	} mmd_op_t;

	typedef struct packed {
		logic valid;
		mmd_op_t op;
		logic ptr_sel;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mmd_req_t;

	typedef struct packed {
		logic done;
		logic [7:0] rdata;
	} mmd_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CODE = 2'b10
	} mmd_top_st_t;

	typedef struct packed {
		mmd_top_st_t st;
		logic [7:0] sp;
		logic [7:0] program_status_word;
		logic [1:0] page;
		logic pf_on;
		mmd_rsp_t rsp;
	} mmd_top_state_t;

	typedef enum logic [1:0] {
		CS_IDLE = 2'b01,
		CS_WAIT = 2'b10
	} mmd_cs_st_t;

	typedef struct packed {
		mmd_cs_st_t st;
		logic [1:0] cnt;
		logic [15:0] addr;
		logic [14:0] tag;
		logic tag_ok;
		logic done;
		logic [7:0] data;
		logic [7:0] lock;
	} mmd_cs_state_t;
endpackage : mmd_pkg

// file: src/mmd_code_store.sv
// program memory with two-byte prefetch line and access wait
`timescale 1ns/1ps
`default_nettype none
module mmd_code_store #(
	parameter int CODE_SIZE = mmd_pkg::CODE_BYTES
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// access request
	input wire logic i_start,
	input wire logic i_fetch,
	input wire logic [15:0] i_addr,
	input wire logic i_pf_on,
	// programming write
	input wire logic i_wr,
	input wire logic [15:0] i_wr_addr,
	input wire logic [7:0] i_wdata,
	// answer
	output logic o_done,
	output logic [7:0] o_data,
	output logic [7:0] o_lock_byte
);
	localparam int AW = $clog2(CODE_SIZE);

	if (CODE_SIZE != 16384)
		$error("code size must be 16384");

	logic [7:0] mem [CODE_SIZE];
	mmd_pkg::mmd_cs_state_t cs;
	mmd_pkg::mmd_cs_state_t next_cs;
	logic hit;
	logic [14:0] line;

	always_comb begin
		next_cs = cs;
		next_cs.done = 1'b0;
		next_cs.lock = mem[AW'(mmd_pkg::CODE_LAST)];
		line = i_addr[15:1];
		hit = cs.tag_ok && (cs.tag == line || 15'(cs.tag + 15'h1) == line);
		unique case (cs.st)
			mmd_pkg::CS_IDLE: begin
				if (i_start) begin
					next_cs.addr = i_addr;
					next_cs.st = mmd_pkg::CS_WAIT;
					if (i_fetch && i_pf_on) begin
						// a hit on the following pair slides the line forward
						next_cs.tag = line;
						next_cs.tag_ok = 1'b1;
						next_cs.cnt = hit ? mmd_pkg::PF_HIT_WAIT : mmd_pkg::PF_MISS_WAIT;
					end else begin
						next_cs.tag_ok = i_pf_on && cs.tag_ok;
						next_cs.cnt = mmd_pkg::FLASH_WAIT;
					end
				end
			end
			mmd_pkg::CS_WAIT: begin
				if (cs.cnt == 2'h0) begin
					next_cs.done = 1'b1;
					next_cs.st = mmd_pkg::CS_IDLE;
					// above the lock byte the space is reserved and reads zero
					next_cs.data = (cs.addr <= mmd_pkg::CODE_LAST) ? mem[cs.addr[AW-1:0]] : 8'h00;
				end else begin
					next_cs.cnt = 2'(cs.cnt - 2'h1);
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cs <= '{st: mmd_pkg::CS_IDLE, cnt: 2'h0, addr: 16'h0000, tag: 15'h0000,
				tag_ok: 1'b0, done: 1'b0, data: 8'h00, lock: 8'h00};
		end else begin
			cs <= next_cs;
		end
	end

	// flash array carries no reset
	always_ff @(posedge i_core_clk) begin
		if (i_wr && i_wr_addr <= mmd_pkg::CODE_LAST) begin
			mem[i_wr_addr[AW-1:0]] <= i_wdata;
		end
	end

	assign o_done = cs.done;
	assign o_data = cs.data;
	assign o_lock_byte = cs.lock;

	property p_miss_wait;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(cs.st == mmd_pkg::CS_IDLE && i_start && i_fetch && i_pf_on && !hit)
			|=> !cs.done [*3] ##1 cs.done;
	endproperty
	a_miss_wait: assert property (p_miss_wait) else $error("prefetch miss wait wrong");

	property p_off_wait;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(cs.st == mmd_pkg::CS_IDLE && i_start && !i_pf_on)
			|=> !cs.done ##1 !cs.done ##1 cs.done;
	endproperty
	a_off_wait: assert property (p_off_wait) else $error("unprefetched fetch wait wrong");
endmodule : mmd_code_store
`default_nettype wire

// file: src/mmd_ram_store.sv
// internal 256-byte ram and on-chip external ram arrays
`timescale 1ns/1ps
`default_nettype none
module mmd_ram_store #(
	parameter int IRAM_SIZE = mmd_pkg::IRAM_BYTES,
	parameter int ONCHIP_EXTERNAL_RAM_SIZE = mmd_pkg::ONCHIP_EXTERNAL_RAM_BYTES
) (
	// clock
	input wire logic i_core_clk,
	// internal ram pointer port
	input wire logic [7:0] i_ptr_addr,
	output logic [7:0] o_ptr_data,
	// internal ram data port
	input wire logic [7:0] i_iaddr,
	input wire logic i_iwe,
	input wire logic [7:0] i_iwdata,
	output logic [7:0] o_idata,
	// external ram port
	input wire logic [mmd_pkg::ONCHIP_EXTERNAL_RAM_AW-1:0] i_xaddr,
	input wire logic i_xwe,
	input wire logic [7:0] i_xwdata,
	output logic [7:0] o_xdata
);
	if (IRAM_SIZE != 256)
		$error("internal ram must be 256 bytes");
	if (ONCHIP_EXTERNAL_RAM_SIZE > 1024 || ONCHIP_EXTERNAL_RAM_SIZE % 256 != 0)
		$error("external ram must be whole pages within 1024 bytes");

	logic [7:0] iram [IRAM_SIZE];
	logic [7:0] onchip_external_ram [ONCHIP_EXTERNAL_RAM_SIZE];
	logic xhit;

	assign xhit = 32'(i_xaddr) < ONCHIP_EXTERNAL_RAM_SIZE;
	assign o_ptr_data = iram[i_ptr_addr];
	assign o_idata = iram[i_iaddr];
	// unpopulated page reads zero
	assign o_xdata = xhit ? onchip_external_ram[i_xaddr] : 8'h00;

	always_ff @(posedge i_core_clk) begin
		if (i_iwe) begin
			iram[i_iaddr] <= i_iwdata;
		end
		if (i_xwe && xhit) begin
			onchip_external_ram[i_xaddr] <= i_xwdata;
		end
	end
endmodule : mmd_ram_store
`default_nettype wire

// file: src/mmd_top.sv
// address decode and storage for code, internal and external data spaces
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - bit 5 of prefetch control enables prefetch; resets to one.
// - other prefetch control bits read zero and ignore writes.
// - program memory is 16 kB at code addresses 0x0000 to 0x3FFF.
// - byte 0x3FFF is the lock byte; higher code addresses are reserved.
// - code reads hit program memory; external moves may be steered to program it.
// - internal ram is 256 bytes; lower half reachable directly and indirectly.
// - above 0x7F direct goes to special registers, indirect to upper ram.
// - 0x00 to 0x1F are four banks of eight registers, one active.
// - indirect pointer comes from working register zero or one of active bank.
// - bytes 0x20 to 0x2F hold bit addresses 0x00 to 0x7F, 8k+n.
// - bit or byte access chosen by instruction kind, not by address.
// - push writes at stack pointer plus one, then increments the pointer.
// - reset sets stack pointer to 0x07; first push lands at 0x08.
// - stack may sit anywhere in 256 bytes and use all of them.
// - 768 bytes of external ram reached by 16-bit or 8-bit external moves.
// - 8-bit external moves take the high address byte from page register.
// - external reads at 0x0300 to 0x03FF return zero.
// - 16-bit external moves to external ram ignore the top six address bits.
// - bank select 00,01,10,11 picks 0x00, 0x08, 0x10, 0x18 blocks.
// - page register field is bits 1:0; upper bits read zero.
// - prefetch miss on a branch stalls up to two extra cycles.
module mmd_top (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// core request
	input wire mmd_pkg::mmd_req_t i_req,
	input wire logic i_xmove_to_code,
	// answer and status
	output mmd_pkg::mmd_rsp_t o_rsp,
	output logic o_pf_on,
	output logic [1:0] o_bank_sel,
	output logic [7:0] o_lock_byte
);
	mmd_pkg::mmd_top_state_t cur;
	mmd_pkg::mmd_top_state_t next_cur;

	logic take;
	logic is_write;
	logic is_bit;
	logic sfr_hit;
	logic cs_start;
	logic cs_fetch;
	logic cs_wr;
	logic cs_done;
	logic [7:0] cs_data;
	logic [15:0] code_wr_addr;
	logic [7:0] ptr_addr;
	logic [7:0] ptr_data;
	logic [7:0] iaddr;
	logic iwe;
	logic [7:0] iwdata;
	logic [7:0] idata;
	logic [mmd_pkg::ONCHIP_EXTERNAL_RAM_AW-1:0] xaddr;
	logic xwe;
	logic [7:0] xdata;
	logic [7:0] byte_in;
	logic [7:0] wr_val;
	logic [7:0] sfr_val;

	mmd_code_store #(
		.CODE_SIZE(mmd_pkg::CODE_BYTES)
	) u_code (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_start(cs_start),
		.i_fetch(cs_fetch),
		.i_addr(i_req.addr),
		.i_pf_on(cur.pf_on),
		.i_wr(cs_wr),
		.i_wr_addr(code_wr_addr),
		.i_wdata(i_req.wdata),
		.o_done(cs_done),
		.o_data(cs_data),
		.o_lock_byte(o_lock_byte)
	);

	mmd_ram_store #(
		.IRAM_SIZE(mmd_pkg::IRAM_BYTES),
		.ONCHIP_EXTERNAL_RAM_SIZE(mmd_pkg::ONCHIP_EXTERNAL_RAM_BYTES)
	) u_ram (
		.i_core_clk(i_core_clk),
		.i_ptr_addr(ptr_addr),
		.o_ptr_data(ptr_data),
		.i_iaddr(iaddr),
		.i_iwe(iwe),
		.i_iwdata(iwdata),
		.o_idata(idata),
		.i_xaddr(xaddr),
		.i_xwe(xwe),
		.i_xwdata(i_req.wdata),
		.o_xdata(xdata)
	);

	// special register read view; unused bits tie to zero
	function automatic logic [7:0] sfr_rd(input logic [7:0] a, input mmd_pkg::mmd_top_state_t s);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			mmd_pkg::PREFETCH_CONTROL_ADDR: v[mmd_pkg::PREFETCH_ON_BIT] = s.pf_on;
			mmd_pkg::ONCHIP_EXTERNAL_RAM_PAGE_REGISTER_ADDR: v = {6'h00, s.page};
			mmd_pkg::PROGRAM_STATUS_WORD_ADDR: v = s.program_status_word;
			mmd_pkg::STACK_POINTER_ADDR: v = s.sp;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : sfr_rd

	always_comb begin
		next_cur = cur;
		next_cur.rsp.done = 1'b0;
		take = cur.st == mmd_pkg::ST_IDLE && i_req.valid;
		cs_start = 1'b0;
		cs_fetch = 1'b0;
		cs_wr = 1'b0;
		iwe = 1'b0;
		xwe = 1'b0;
		// pointer is work_reg_zero or work_reg_one of the active bank
		ptr_addr = {3'h0, cur.program_status_word[mmd_pkg::BANK_SELECT_HIGH_BIT:mmd_pkg::BANK_SELECT_LOW_BIT],
			2'h0, i_req.ptr_sel};
		is_bit = i_req.op == mmd_pkg::OP_BIT_RD || i_req.op == mmd_pkg::OP_BIT_WR;
		is_write = i_req.op == mmd_pkg::OP_DIR_WR || i_req.op == mmd_pkg::OP_IND_WR ||
			i_req.op == mmd_pkg::OP_BIT_WR || i_req.op == mmd_pkg::OP_PUSH;
		unique case (i_req.op)
			mmd_pkg::OP_IND_RD, mmd_pkg::OP_IND_WR: iaddr = ptr_data;
			mmd_pkg::OP_PUSH: iaddr = 8'(cur.sp + 8'h01);
			mmd_pkg::OP_POP: iaddr = cur.sp;
			mmd_pkg::OP_BIT_RD, mmd_pkg::OP_BIT_WR: begin
				// bit n of byte 0x20+k is bit address 8k+n; upper bit addresses hit registers
				iaddr = i_req.addr[7] ? {i_req.addr[7:3], 3'h0} :
					8'(mmd_pkg::BIT_AREA_BASE + {4'h0, i_req.addr[6:3]});
			end
			default: iaddr = i_req.addr[7:0];
		endcase
		// only direct and bit operands above 0x7f land on special registers
		sfr_hit = (i_req.op == mmd_pkg::OP_DIR_RD || i_req.op == mmd_pkg::OP_DIR_WR || is_bit) &&
			iaddr > mmd_pkg::DIRECT_LAST;
		sfr_val = sfr_rd(iaddr, cur);
		byte_in = sfr_hit ? sfr_val : idata;
		wr_val = i_req.wdata;
		if (is_bit) begin
			wr_val = byte_in;
			wr_val[i_req.addr[2:0]] = i_req.wdata[0];
		end
		iwdata = wr_val;
		if (i_req.op == mmd_pkg::OP_X8_RD || i_req.op == mmd_pkg::OP_X8_WR) begin
			xaddr = {cur.page, i_req.addr[7:0]};
			code_wr_addr = {6'h00, cur.page, i_req.addr[7:0]};
		end else begin
			xaddr = i_req.addr[mmd_pkg::ONCHIP_EXTERNAL_RAM_AW-1:0];
			code_wr_addr = i_req.addr;
		end
		unique case (cur.st)
			mmd_pkg::ST_IDLE: begin
				if (take) begin
					next_cur.rsp.done = 1'b1;
					unique case (i_req.op)
						mmd_pkg::OP_FETCH, mmd_pkg::OP_CODE_RD: begin
							cs_start = 1'b1;
							cs_fetch = i_req.op == mmd_pkg::OP_FETCH;
							next_cur.rsp.done = 1'b0;
							next_cur.st = mmd_pkg::ST_CODE;
						end
						mmd_pkg::OP_X8_RD, mmd_pkg::OP_X16_RD: next_cur.rsp.rdata = xdata;
						mmd_pkg::OP_X8_WR, mmd_pkg::OP_X16_WR: begin
							cs_wr = i_xmove_to_code;
							xwe = !i_xmove_to_code;
						end
						mmd_pkg::OP_BIT_RD: next_cur.rsp.rdata = {7'h00, byte_in[i_req.addr[2:0]]};
						default: next_cur.rsp.rdata = byte_in;
					endcase
					if (i_req.op == mmd_pkg::OP_POP) begin
						next_cur.sp = 8'(cur.sp - 8'h01);
					end
					if (is_write && !sfr_hit) begin
						iwe = 1'b1;
					end
					if (is_write && sfr_hit) begin
						unique case (iaddr)
							mmd_pkg::PREFETCH_CONTROL_ADDR:
								next_cur.pf_on = wr_val[mmd_pkg::PREFETCH_ON_BIT];
							mmd_pkg::ONCHIP_EXTERNAL_RAM_PAGE_REGISTER_ADDR: next_cur.page = wr_val[1:0];
							mmd_pkg::PROGRAM_STATUS_WORD_ADDR: next_cur.program_status_word = {wr_val[7:1], 1'b0};
							mmd_pkg::STACK_POINTER_ADDR: next_cur.sp = wr_val;
							default: next_cur.page = cur.page;
						endcase
					end
					if (i_req.op == mmd_pkg::OP_PUSH) begin
						next_cur.sp = 8'(cur.sp + 8'h01);
					end
				end
			end
			mmd_pkg::ST_CODE: begin
				if (cs_done) begin
					next_cur.rsp.done = 1'b1;
					next_cur.rsp.rdata = cs_data;
					next_cur.st = mmd_pkg::ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur <= '{st: mmd_pkg::ST_IDLE, sp: mmd_pkg::SP_RESET, program_status_word: mmd_pkg::PSW_RESET,
				page: mmd_pkg::PAGE_RESET,
				pf_on: mmd_pkg::PREFETCH_CONTROL_RESET[mmd_pkg::PREFETCH_ON_BIT],
				rsp: '{done: 1'b0, rdata: 8'h00}};
		end else begin
			cur <= next_cur;
		end
	end

	assign o_rsp = cur.rsp;
	assign o_pf_on = cur.pf_on;
	assign o_bank_sel = cur.program_status_word[mmd_pkg::BANK_SELECT_HIGH_BIT:mmd_pkg::BANK_SELECT_LOW_BIT];

	property p_pf_write;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && i_req.op == mmd_pkg::OP_DIR_WR && i_req.addr[7:0] == 8'hb5)
			|=> o_pf_on == $past(i_req.wdata[5]);
	endproperty
	a_pf_write: assert property (p_pf_write) else $error("prefetch enable not stored");

	property p_pf_read;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && i_req.op == mmd_pkg::OP_DIR_RD && i_req.addr[7:0] == 8'hb5)
			|=> o_rsp.done && o_rsp.rdata == {2'h0, o_pf_on, 5'h00};
	endproperty
	a_pf_read: assert property (p_pf_read) else $error("prefetch control readback wrong");

	property p_sp_reset;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!$past(i_rst_n) |-> cur.sp == 8'h07;
	endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("stack pointer reset value wrong");

	property p_push;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && i_req.op == mmd_pkg::OP_PUSH)
			|-> iwe && iaddr == 8'(cur.sp + 8'h01) ##1 cur.sp == 8'($past(cur.sp) + 8'h01);
	endproperty
	a_push: assert property (p_push) else $error("push address or pointer step wrong");

	property p_direct_high;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && i_req.op == mmd_pkg::OP_DIR_WR && i_req.addr[7]) |-> !iwe;
	endproperty
	a_direct_high: assert property (p_direct_high) else $error("direct high write hit ram");

	property p_indirect_ptr;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && i_req.op == mmd_pkg::OP_IND_RD)
			|-> ptr_addr == {3'h0, o_bank_sel, 2'h0, i_req.ptr_sel} && iaddr == ptr_data;
	endproperty
	a_indirect_ptr: assert property (p_indirect_ptr) else $error("indirect pointer wrong");

	property p_x_zero;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && i_req.op == mmd_pkg::OP_X16_RD && i_req.addr[9:8] == 2'h3)
			|=> o_rsp.done && o_rsp.rdata == 8'h00;
	endproperty
	a_x_zero: assert property (p_x_zero) else $error("unpopulated page not zero");

	property p_x16_alias;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && i_req.op == mmd_pkg::OP_X16_WR) |-> xaddr == i_req.addr[9:0];
	endproperty
	a_x16_alias: assert property (p_x16_alias) else $error("16-bit alias wrong");

	property p_code_bound;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && i_req.op == mmd_pkg::OP_CODE_RD && i_req.addr > 16'h3fff)
			|-> ##[2:5] (o_rsp.done && o_rsp.rdata == 8'h00);
	endproperty
	a_code_bound: assert property (p_code_bound) else $error("reserved code not zero");

	property p_ind_ram;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && i_req.op == mmd_pkg::OP_IND_WR && ptr_data > 8'h7f) |-> iwe;
	endproperty
	a_ind_ram: assert property (p_ind_ram) else $error("indirect high write missed ram");

	property p_bit_byte;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && i_req.op == mmd_pkg::OP_BIT_WR && !i_req.addr[7])
			|-> iwe && iaddr == {4'h2, i_req.addr[6:3]};
	endproperty
	a_bit_byte: assert property (p_bit_byte) else $error("bit area byte wrong");

	property p_x8_page;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && (i_req.op == mmd_pkg::OP_X8_RD || i_req.op == mmd_pkg::OP_X8_WR))
			|-> xaddr[9:8] == cur.page && xaddr[7:0] == i_req.addr[7:0];
	endproperty
	a_x8_page: assert property (p_x8_page) else $error("8-bit external page wrong");

	property p_bank_top;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(take && i_req.op == mmd_pkg::OP_IND_WR && o_bank_sel == 2'h3)
			|-> ptr_addr[7:3] == 5'h03;
	endproperty
	a_bank_top: assert property (p_bank_top) else $error("bank three pointer wrong");
endmodule : mmd_top
`default_nettype wire

// file: verification/mmd_core_model.sv
// core-side model that issues one request at a time and times the answer
`timescale 1ns/1ps
`default_nettype none
module mmd_core_model (
	// clock
	input wire logic i_core_clk,
	// answer from the decoder
	input wire mmd_pkg::mmd_rsp_t i_rsp,
	// request to the decoder
	output var mmd_pkg::mmd_req_t o_req
);
	logic [7:0] rdata;
	logic [7:0] lat;

	initial begin
		o_req = '0;
		rdata = 8'h00;
		lat = 8'h00;
	end

	// valid stands for one edge only: a held request would be taken twice
	task automatic access(input mmd_pkg::mmd_op_t op, input logic [15:0] a, input logic [7:0] d,
		input logic p);
		@(posedge i_core_clk);
		o_req <= '{valid: 1'b1, op: op, ptr_sel: p, addr: a, wdata: d};
		@(posedge i_core_clk);
		// released address and data flip so stale values cannot pass for held ones
		o_req.valid <= 1'b0;
		o_req.addr <= ~a;
		o_req.wdata <= ~d;
		lat = 8'h00;
		rdata = 8'h00;
		// a data answer stands only until the edge after the taking edge
		while (lat < 8'h10) begin
			#1;
			if (i_rsp.done === 1'b1) begin
				rdata = i_rsp.rdata;
				break;
			end
			@(posedge i_core_clk);
			lat = lat + 8'h01;
		end
	endtask : access
endmodule : mmd_core_model
`default_nettype wire

// file: verification/tb_mmd_top.sv
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module tb_mmd_top;
	logic i_core_clk;
	logic i_rst_n;
	logic i_xmove_to_code;
	mmd_pkg::mmd_req_t req;
	mmd_pkg::mmd_rsp_t rsp;
	logic pf_on;
	logic [1:0] bank_sel;
	logic [7:0] lock_byte;
	int fail_count;
	int num_checks;

	mmd_top i_mmd_top (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_req(req),
		.i_xmove_to_code(i_xmove_to_code),
		.o_rsp(rsp),
		.o_pf_on(pf_on),
		.o_bank_sel(bank_sel),
		.o_lock_byte(lock_byte)
	);

	mmd_core_model i_mmd_core_model (
		.i_core_clk(i_core_clk),
		.i_rsp(rsp),
		.o_req(req)
	);

	always #50 i_core_clk = ~i_core_clk;

	task automatic report_and_stop();
		if (fail_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk

	// a missing answer counts as a mismatch
	task automatic acc(input mmd_pkg::mmd_op_t op, input logic [15:0] a, input logic [7:0] d,
		input logic p);
		i_mmd_core_model.access(op, a, d, p);
		if (i_mmd_core_model.lat == 8'h10) begin
			chk(8'h10, 8'h00);
		end
	endtask : acc

	task automatic rd(input mmd_pkg::mmd_op_t op, input logic [15:0] a, input logic p,
		input logic [7:0] exp);
		acc(op, a, 8'h00, p);
		chk(i_mmd_core_model.rdata, exp);
	endtask : rd

	task automatic dw(input logic [7:0] a, input logic [7:0] d);
		acc(mmd_pkg::OP_DIR_WR, {8'h00, a}, d, 1'b0);
	endtask : dw

	task automatic dr(input logic [7:0] a, input logic [7:0] exp);
		rd(mmd_pkg::OP_DIR_RD, {8'h00, a}, 1'b0, exp);
	endtask : dr

	task automatic lt(input logic [7:0] exp);
		chk(i_mmd_core_model.lat, exp);
	endtask : lt

	// watchdog, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (3000) @(posedge i_core_clk);
		fail_count++;
		report_and_stop();
	end

	initial begin
		i_core_clk = 1'b0;
		i_rst_n = 1'b0;
		i_xmove_to_code = 1'b0;
		fail_count = 0;
		num_checks = 0;
		repeat (6) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		chk({7'h00, pf_on}, 8'h01);
		chk({6'h00, bank_sel}, 8'h00);
		dr(8'hb5, 8'h20);
		dr(8'h81, 8'h07);
		dr(8'haa, 8'h00);
		// stack
		acc(mmd_pkg::OP_PUSH, 16'h0000, 8'hab, 1'b0);
		dr(8'h08, 8'hab);
		dr(8'h81, 8'h08);
		rd(mmd_pkg::OP_POP, 16'h0000, 1'b0, 8'hab);
		dr(8'h81, 8'h07);
		dw(8'h81, 8'hfe);
		acc(mmd_pkg::OP_PUSH, 16'h0000, 8'h3c, 1'b0);
		dw(8'h00, 8'hff);
		rd(mmd_pkg::OP_IND_RD, 16'h0000, 1'b0, 8'h3c);
		dr(8'h81, 8'hff);
		// prefetch control
		dw(8'hb5, 8'hff);
		dr(8'hb5, 8'h20);
		dw(8'hb5, 8'h00);
		dr(8'hb5, 8'h00);
		chk({7'h00, pf_on}, 8'h00);
		// banks and pointers
		for (int b = 0; b < 4; b++) begin
			dw(8'hd0, 8'(b << 3));
			chk({6'h00, bank_sel}, 8'(b));
			dr(8'hd0, 8'(b << 3));
			dw(8'(8 * b + 1), 8'(8'h40 + b));
			acc(mmd_pkg::OP_IND_WR, 16'h0000, 8'(8'h60 + b), 1'b1);
			dr(8'(8'h40 + b), 8'(8'h60 + b));
		end
		dw(8'hd0, 8'h00);
		// upper ram against special space
		dw(8'h01, 8'h90);
		acc(mmd_pkg::OP_IND_WR, 16'h0000, 8'hc3, 1'b1);
		dr(8'h90, 8'h00);
		rd(mmd_pkg::OP_IND_RD, 16'h0000, 1'b1, 8'hc3);
		dw(8'h30, 8'h5e);
		dw(8'h00, 8'h30);
		rd(mmd_pkg::OP_IND_RD, 16'h0000, 1'b0, 8'h5e);
		// bit area
		dw(8'h22, 8'h00);
		dw(8'h2f, 8'h00);
		dw(8'h7f, 8'h00);
		acc(mmd_pkg::OP_BIT_WR, 16'h0013, 8'h01, 1'b0);
		acc(mmd_pkg::OP_BIT_WR, 16'h007f, 8'h01, 1'b0);
		dr(8'h22, 8'h08);
		dr(8'h2f, 8'h80);
		dr(8'h7f, 8'h00);
		acc(mmd_pkg::OP_BIT_RD, 16'h0013, 8'h00, 1'b0);
		chk({7'h00, i_mmd_core_model.rdata[0]}, 8'h01);
		// external space
		acc(mmd_pkg::OP_X16_WR, 16'h0005, 8'h66, 1'b0);
		rd(mmd_pkg::OP_X16_RD, 16'hfc05, 1'b0, 8'h66);
		acc(mmd_pkg::OP_X16_WR, 16'h0302, 8'hff, 1'b0);
		rd(mmd_pkg::OP_X16_RD, 16'h0302, 1'b0, 8'h00);
		dw(8'haa, 8'hff);
		dr(8'haa, 8'h03);
		dw(8'haa, 8'h02);
		acc(mmd_pkg::OP_X16_WR, 16'h0207, 8'h99, 1'b0);
		rd(mmd_pkg::OP_X8_RD, 16'h0007, 1'b0, 8'h99);
		acc(mmd_pkg::OP_X8_WR, 16'h0008, 8'h12, 1'b0);
		rd(mmd_pkg::OP_X16_RD, 16'h0208, 1'b0, 8'h12);
		// external moves steered into code memory
		acc(mmd_pkg::OP_X16_WR, 16'h0100, 8'h33, 1'b0);
		@(posedge i_core_clk);
		i_xmove_to_code <= 1'b1;
		acc(mmd_pkg::OP_X16_WR, 16'h0100, 8'h5a, 1'b0);
		acc(mmd_pkg::OP_X16_WR, 16'h0000, 8'h77, 1'b0);
		acc(mmd_pkg::OP_X16_WR, 16'h3fff, 8'ha5, 1'b0);
		acc(mmd_pkg::OP_X16_WR, 16'h4000, 8'h11, 1'b0);
		@(posedge i_core_clk);
		i_xmove_to_code <= 1'b0;
		rd(mmd_pkg::OP_X16_RD, 16'h0100, 1'b0, 8'h33);
		rd(mmd_pkg::OP_CODE_RD, 16'h0000, 1'b0, 8'h77);
		lt(8'h03);
		rd(mmd_pkg::OP_CODE_RD, 16'h0100, 1'b0, 8'h5a);
		chk(lock_byte, 8'ha5);
		rd(mmd_pkg::OP_CODE_RD, 16'h4000, 1'b0, 8'h00);
		// fetch timing, prefetch off then on
		rd(mmd_pkg::OP_FETCH, 16'h0100, 1'b0, 8'h5a);
		lt(8'h03);
		dw(8'hb5, 8'h20);
		chk({7'h00, pf_on}, 8'h01);
		rd(mmd_pkg::OP_FETCH, 16'h0000, 1'b0, 8'h77);
		lt(8'h04);
		acc(mmd_pkg::OP_FETCH, 16'h0001, 8'h00, 1'b0);
		lt(8'h02);
		acc(mmd_pkg::OP_FETCH, 16'h0002, 8'h00, 1'b0);
		lt(8'h02);
		rd(mmd_pkg::OP_FETCH, 16'h0100, 1'b0, 8'h5a);
		lt(8'h04);
		// mid-run reset brings pointer and prefetch enable back
		dw(8'hb5, 8'h00);
		@(posedge i_core_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		chk({7'h00, pf_on}, 8'h01);
		dr(8'h81, 8'h07);
		report_and_stop();
	end
endmodule : tb_mmd_top
`default_nettype wire
